// *** mrs_pkg.sv ***
// constants, op codes and state codes for the return, rotate, subtract and sleep datapath
package mrs_pkg;
   // ***********************************************
   // widths
   // ***********************************************
   localparam int DATA_W = 8;
   localparam int NIB_W  = 4;
   localparam int PC_W   = 11;

   // ***********************************************
   // destination select encoding
   // ***********************************************
   localparam logic DEST_WORK = 1'b0;
   localparam logic DEST_FILE = 1'b1;

   // ***********************************************
   // reset values and fixed flag values
   // ***********************************************
   localparam logic [DATA_W-1:0] RST_WORK = 8'h00;
   localparam logic [PC_W-1:0]   RST_PC   = 11'h000;
   localparam logic RST_CARRY   = 1'b0;
   localparam logic RST_NIBC    = 1'b0;
   localparam logic RST_ZERO    = 1'b0;
   localparam logic RST_GIE     = 1'b0;
   localparam logic RST_EXPIRY  = 1'b1;
   localparam logic RST_SLEEPFL = 1'b1;
   localparam logic GIE_ON      = 1'b1;
   localparam logic EXPIRY_SLP  = 1'b1;
   localparam logic SLEEPFL_SLP = 1'b0;
   localparam logic NO_BORROW   = 1'b1;

   // ***********************************************
   // operations issued by the decoder
   // ***********************************************
   typedef enum logic [3:0] {
      OP_NONE              = 4'h0,
      IRQ_RETURN_OP        = 4'h1,
      RETURN_WITH_LITERAL_OP = 4'h2,
      SUB_RETURN_OP        = 4'h3,
      ROTATE_LEFT_OP       = 4'h4,
      ROTATE_RIGHT_OP      = 4'h5,
      SUB_BORROW_OP        = 4'h6,
      REG_MINUS_WORK_OP    = 4'h7,
      LITERAL_MINUS_WORK_OP = 4'h8,
      NIBBLE_EXCHANGE_OP   = 4'h9,
      XOR_REG_OP           = 4'ha,
      XOR_LITERAL_OP       = 4'hb,
      SLEEP_OP             = 4'hc
   } mrs_op_type;

   // ***********************************************
   // sequencer states, one-hot
   // ***********************************************
   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_RET   = 3'b010,
      ST_SLEEP = 3'b100
   } mrs_state_type;
endpackage

// *** mrs_exec.sv ***
// execution unit for returns, rotates, subtracts, nibble exchange, xor and sleep
`timescale 1ns/1ns
// Overview of operation
// - the interrupt return reloads the program counter from the stack top.
// - the interrupt return also sets the global interrupt enable and takes two cycles.
// - return with literal loads the literal into work, reloads the pc, two cycles, no flags.
// - the plain return reloads the pc from the stack top, no flags, two cycles.
// - rotate left sends bit 7 to carry, bits 6..0 up one, old carry into bit 0.
// - rotate right sends old carry into bit 7, bits 7..1 down one, bit 0 to carry.
// - destination select 0 writes the work register, 1 writes the file register.
// - sleep clears the watchdog counter and its prescaler.
// - sleep sets the active-low expiry flag and clears the active-low sleep entry flag.
// - after the one-cycle sleep the core halts and stays in sleep until wake_i is high.
// - subtract with borrow forms file plus inverted work plus carry and sets c, dc, z.
// - register subtract forms file minus work and sets c, dc, z.
// - literal subtract forms literal minus work into work and sets c, dc, z.
// - nibble exchange swaps the two halves into the chosen destination, no flags.
// - register xor forms work xor file into the destination, only zero, one cycle.
// - literal xor forms work xor literal into work, only zero changes.
module mrs_exec #(
   parameter int PC_W = mrs_pkg::PC_W
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      op_valid_i,
   input  wire mrs_pkg::mrs_op_type       op_i,
   input  wire logic [mrs_pkg::DATA_W-1:0] file_reg_i,
   input  wire logic [mrs_pkg::DATA_W-1:0] literal_i,
   input  wire logic                      dest_sel_i,
   input  wire logic [PC_W-1:0]           stack_top_i,
   input  wire logic                      wake_i,
   output logic [mrs_pkg::DATA_W-1:0]     work_register_o,
   output logic [mrs_pkg::DATA_W-1:0]     file_wdata_o,
   output logic                           file_wr_o,
   output logic                           carry_o,
   output logic                           nibble_carry_flag_o,
   output logic                           zero_o,
   output logic                           global_irq_enable_o,
   output logic [PC_W-1:0]                pc_o,
   output logic                           pc_load_o,
   output logic                           stack_pop_o,
   output logic                           watchdog_clear_o,
   output logic                           prescaler_clear_o,
   output logic                           watchdog_expiry_flag_o,
   output logic                           sleep_entry_flag_o,
   output logic                           sleep_o,
   output logic                           busy_o
);
   localparam int DW = mrs_pkg::DATA_W;
   localparam int NW = mrs_pkg::NIB_W;

   mrs_pkg::mrs_state_type state_r;
   mrs_pkg::mrs_state_type state_nxt;
   logic [DW-1:0]   work_r;
   logic [DW-1:0]   wdata_r;
   logic            wr_r;
   logic            carry_r;
   logic            nibc_r;
   logic            zero_r;
   logic            gie_r;
   logic [PC_W-1:0] pc_r;
   logic            pc_load_r;
   logic            wdt_clr_r;
   logic            expiry_r;
   logic            sleepfl_r;
   logic            take;
   logic            is_ret;
   logic [DW-1:0]   res_nxt;
   logic            carry_nxt;
   logic            nibc_nxt;
   logic            zero_nxt;
   logic            alu_op;
   logic            to_work;
   logic [DW-1:0]   add_a;
   logic [DW-1:0]   add_b;
   logic            add_cin;
   logic [DW:0]     sum_full;
   logic [NW:0]     sum_nib;

   // ***********************************************
   // issue and decode
   // ***********************************************
   // ops are only taken while running; the second return cycle and sleep ignore them
   assign take   = op_valid_i && (state_r == mrs_pkg::ST_RUN);
   assign is_ret = (op_i == mrs_pkg::IRQ_RETURN_OP) ||
                   (op_i == mrs_pkg::RETURN_WITH_LITERAL_OP) ||
                   (op_i == mrs_pkg::SUB_RETURN_OP);

   // shared adder: a + b + cin, b already inverted for subtracts
   assign sum_full = (DW+1)'(add_a) + (DW+1)'(add_b) + (DW+1)'(add_cin);
   assign sum_nib  = (NW+1)'(add_a[NW-1:0]) + (NW+1)'(add_b[NW-1:0]) + (NW+1)'(add_cin);

   // result and flag next values; non-alu ops leave alu_op low
   always_comb begin
      res_nxt   = file_reg_i;
      carry_nxt = carry_r;
      nibc_nxt  = nibc_r;
      zero_nxt  = zero_r;
      alu_op    = 1'b1;
      to_work   = (dest_sel_i == mrs_pkg::DEST_WORK);
      add_a     = file_reg_i;
      add_b     = ~work_r;
      add_cin   = mrs_pkg::NO_BORROW;
      case (op_i)
         mrs_pkg::ROTATE_LEFT_OP: begin
            res_nxt   = {file_reg_i[DW-2:0], carry_r};
            carry_nxt = file_reg_i[DW-1];
         end
         mrs_pkg::ROTATE_RIGHT_OP: begin
            res_nxt   = {carry_r, file_reg_i[DW-1:1]};
            carry_nxt = file_reg_i[0];
         end
         mrs_pkg::SUB_BORROW_OP: begin
            add_cin   = carry_r;
            res_nxt   = sum_full[DW-1:0];
            carry_nxt = sum_full[DW];
            nibc_nxt  = sum_nib[NW];
            zero_nxt  = (sum_full[DW-1:0] == '0);
         end
         mrs_pkg::REG_MINUS_WORK_OP: begin
            res_nxt   = sum_full[DW-1:0];
            carry_nxt = sum_full[DW];
            nibc_nxt  = sum_nib[NW];
            zero_nxt  = (sum_full[DW-1:0] == '0);
         end
         mrs_pkg::LITERAL_MINUS_WORK_OP: begin
            add_a     = literal_i;
            to_work   = 1'b1;
            res_nxt   = sum_full[DW-1:0];
            carry_nxt = sum_full[DW];
            nibc_nxt  = sum_nib[NW];
            zero_nxt  = (sum_full[DW-1:0] == '0);
         end
         mrs_pkg::NIBBLE_EXCHANGE_OP: begin
            res_nxt = {file_reg_i[NW-1:0], file_reg_i[DW-1:NW]};
         end
         mrs_pkg::XOR_REG_OP: begin
            res_nxt  = work_r ^ file_reg_i;
            zero_nxt = ((work_r ^ file_reg_i) == '0);
         end
         mrs_pkg::XOR_LITERAL_OP: begin
            to_work  = 1'b1;
            res_nxt  = work_r ^ literal_i;
            zero_nxt = ((work_r ^ literal_i) == '0);
         end
         default: begin
            alu_op = 1'b0;
         end
      endcase
   end

   // ***********************************************
   // sequencer
   // ***********************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         mrs_pkg::ST_RUN: begin
            if (take && is_ret) begin
               state_nxt = mrs_pkg::ST_RET;
            end else if (take && (op_i == mrs_pkg::SLEEP_OP)) begin
               state_nxt = mrs_pkg::ST_SLEEP;
            end
         end
         mrs_pkg::ST_RET: begin
            state_nxt = mrs_pkg::ST_RUN; // second and last return cycle
         end
         mrs_pkg::ST_SLEEP: begin
            if (wake_i) begin
               state_nxt = mrs_pkg::ST_RUN;
            end
         end
         default: begin
            state_nxt = mrs_pkg::ST_RUN;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_r <= mrs_pkg::ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ***********************************************
   // state registers: work, file write, flags, pc and power status
   // ***********************************************
   // file data always shows the last result so a debugger can watch it
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         work_r  <= mrs_pkg::RST_WORK;
         wdata_r <= mrs_pkg::RST_WORK;
         wr_r    <= 1'b0;
      end else begin
         wr_r <= 1'b0;
         if (take && alu_op) begin
            wdata_r <= res_nxt;
            if (to_work) begin
               work_r <= res_nxt;
            end else begin
               wr_r <= 1'b1;
            end
         end else if (take && (op_i == mrs_pkg::RETURN_WITH_LITERAL_OP)) begin
            work_r <= literal_i;
         end
      end
   end

   // arithmetic flags; returns and sleep leave them, swap rewrites the same values
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         carry_r <= mrs_pkg::RST_CARRY;
         nibc_r  <= mrs_pkg::RST_NIBC;
         zero_r  <= mrs_pkg::RST_ZERO;
      end else if (take && alu_op) begin
         carry_r <= carry_nxt;
         nibc_r  <= nibc_nxt;
         zero_r  <= zero_nxt;
      end
   end

   // pc reload and interrupt enable; the enable is only ever set here
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pc_r      <= PC_W'(mrs_pkg::RST_PC);
         pc_load_r <= 1'b0;
         gie_r     <= mrs_pkg::RST_GIE;
      end else begin
         pc_load_r <= take && is_ret; // one pulse, also pops the stack
         if (take && is_ret) begin
            pc_r <= stack_top_i;
         end
         if (take && (op_i == mrs_pkg::IRQ_RETURN_OP)) begin
            gie_r <= mrs_pkg::GIE_ON;
         end
      end
   end

   // watchdog clear pulse and power status flags; the counter itself lives elsewhere
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wdt_clr_r <= 1'b0;
         expiry_r  <= mrs_pkg::RST_EXPIRY;
         sleepfl_r <= mrs_pkg::RST_SLEEPFL;
      end else begin
         wdt_clr_r <= take && (op_i == mrs_pkg::SLEEP_OP);
         if (take && (op_i == mrs_pkg::SLEEP_OP)) begin
            expiry_r  <= mrs_pkg::EXPIRY_SLP;
            sleepfl_r <= mrs_pkg::SLEEPFL_SLP;
         end
      end
   end

   // outputs wired straight from their flops
   assign work_register_o        = work_r;
   assign file_wdata_o           = wdata_r;
   assign file_wr_o              = wr_r;
   assign carry_o                = carry_r;
   assign nibble_carry_flag_o    = nibc_r;
   assign zero_o                 = zero_r;
   assign global_irq_enable_o    = gie_r;
   assign pc_o                   = pc_r;
   assign pc_load_o              = pc_load_r;
   assign stack_pop_o            = pc_load_r;
   assign watchdog_clear_o       = wdt_clr_r;
   assign prescaler_clear_o      = wdt_clr_r;
   assign watchdog_expiry_flag_o = expiry_r;
   assign sleep_entry_flag_o     = sleepfl_r;
   assign sleep_o                = state_r[2];
   assign busy_o                 = state_r[1];

   // ***********************************************
   // assertions
   // ***********************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   AST_IRQ_RET_PC: assert property (
      take && op_i == mrs_pkg::IRQ_RETURN_OP |=> pc_load_o && pc_o == $past(stack_top_i))
      else $error("interrupt return did not reload pc");
   AST_IRQ_RET_GIE: assert property (
      take && op_i == mrs_pkg::IRQ_RETURN_OP |=> global_irq_enable_o && busy_o ##1 !busy_o)
      else $error("interrupt return enable or length wrong");
   AST_RETLIT: assert property (
      take && op_i == mrs_pkg::RETURN_WITH_LITERAL_OP |=>
      work_register_o == $past(literal_i) && carry_o == $past(carry_o) &&
      zero_o == $past(zero_o) && pc_o == $past(stack_top_i))
      else $error("return with literal wrong");
   AST_RET_TWO: assert property (
      take && is_ret |=> busy_o && !take ##1 !busy_o && !pc_load_o)
      else $error("return not two cycles");
   AST_ROTL: assert property (
      take && op_i == mrs_pkg::ROTATE_LEFT_OP |=>
      file_wdata_o == {$past(file_reg_i[DW-2:0]), $past(carry_o)} &&
      carry_o == $past(file_reg_i[DW-1]) && zero_o == $past(zero_o))
      else $error("rotate left wrong");
   AST_ROTR: assert property (
      take && op_i == mrs_pkg::ROTATE_RIGHT_OP |=>
      file_wdata_o == {$past(carry_o), $past(file_reg_i[DW-1:1])} &&
      carry_o == $past(file_reg_i[0]))
      else $error("rotate right wrong");
   AST_DEST: assert property (
      take && op_i == mrs_pkg::NIBBLE_EXCHANGE_OP && dest_sel_i == mrs_pkg::DEST_WORK |=>
      !file_wr_o && work_register_o == file_wdata_o)
      else $error("destination select wrong");
   AST_SLEEP: assert property (
      take && op_i == mrs_pkg::SLEEP_OP |=> watchdog_clear_o && prescaler_clear_o &&
      watchdog_expiry_flag_o && !sleep_entry_flag_o ##1 !watchdog_clear_o)
      else $error("sleep effects wrong");
   AST_SLEEP_HOLD: assert property (
      sleep_o && !wake_i |=> sleep_o && !pc_load_o && !file_wr_o)
      else $error("core ran while asleep");
   AST_SUB: assert property (
      take && op_i == mrs_pkg::REG_MINUS_WORK_OP |=>
      file_wdata_o == DW'($past(file_reg_i) - $past(work_register_o)) &&
      carry_o == ($past(file_reg_i) >= $past(work_register_o)) &&
      zero_o == (file_wdata_o == '0))
      else $error("register subtract wrong");
   AST_SUBLIT: assert property (
      take && op_i == mrs_pkg::LITERAL_MINUS_WORK_OP |=>
      work_register_o == DW'($past(literal_i) - $past(work_register_o)) &&
      nibble_carry_flag_o ==
      ($past(literal_i[NW-1:0]) >= $past(work_register_o[NW-1:0])))
      else $error("literal subtract wrong");
   AST_XOR: assert property (
      take && op_i == mrs_pkg::XOR_REG_OP |=>
      file_wdata_o == ($past(file_reg_i) ^ $past(work_register_o)) &&
      carry_o == $past(carry_o) && zero_o == (file_wdata_o == '0) && !busy_o)
      else $error("register xor wrong");

   COV_IRQ_RET: cover property (take && op_i == mrs_pkg::IRQ_RETURN_OP ##2 take);
   COV_SLEEP_WAKE: cover property (take && op_i == mrs_pkg::SLEEP_OP ##[1:20] wake_i);
   COV_SBC_FILE: cover property (take && op_i == mrs_pkg::SUB_BORROW_OP && dest_sel_i);
endmodule

// *** mcu_alu_return_sleep_exec_test.sv ***
// self-checking bench for the return, rotate, subtract, xor and sleep datapath
`timescale 1ns/1ns
module mcu_alu_return_sleep_exec_test;
   // ******************************
   // stimulus and observed signals
   // ******************************
   logic                       clk_i;
   logic                       rst_n_i;
   logic                       op_valid_i;
   mrs_pkg::mrs_op_type        op_i;
   logic [7:0]                 file_reg_i;
   logic [7:0]                 literal_i;
   logic                       dest_sel_i;
   logic [mrs_pkg::PC_W-1:0]   stack_top_i;
   logic                       wake_i;
   logic [7:0]                 work_o;
   logic [7:0]                 wdata_o;
   logic                       file_wr_o;
   logic                       carry_o;
   logic                       dc_o;
   logic                       zero_o;
   logic                       gie_o;
   logic [mrs_pkg::PC_W-1:0]   pc_o;
   logic                       pc_load_o;
   logic                       pop_o;
   logic                       wdt_clr_o;
   logic                       pre_clr_o;
   logic                       expiry_o;
   logic                       entry_o;
   logic                       sleep_o;
   logic                       busy_o;
   int                         fails;
   int                         tests_run;
   // expected architectural state, kept by the bench alone
   logic [7:0]                 exp_w;
   logic                       exp_c;
   logic                       exp_dc;
   logic                       exp_z;
   logic                       exp_gie;

   mrs_exec #(.PC_W(mrs_pkg::PC_W)) dut (
      .clk_i                  (clk_i),
      .rst_n_i                (rst_n_i),
      .op_valid_i             (op_valid_i),
      .op_i                   (op_i),
      .file_reg_i             (file_reg_i),
      .literal_i              (literal_i),
      .dest_sel_i             (dest_sel_i),
      .stack_top_i            (stack_top_i),
      .wake_i                 (wake_i),
      .work_register_o        (work_o),
      .file_wdata_o           (wdata_o),
      .file_wr_o              (file_wr_o),
      .carry_o                (carry_o),
      .nibble_carry_flag_o    (dc_o),
      .zero_o                 (zero_o),
      .global_irq_enable_o    (gie_o),
      .pc_o                   (pc_o),
      .pc_load_o              (pc_load_o),
      .stack_pop_o            (pop_o),
      .watchdog_clear_o       (wdt_clr_o),
      .prescaler_clear_o      (pre_clr_o),
      .watchdog_expiry_flag_o (expiry_o),
      .sleep_entry_flag_o     (entry_o),
      .sleep_o                (sleep_o),
      .busy_o                 (busy_o)
   );

   // 125 MHz core clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // ******************************
   // shared helpers
   // ******************************
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
      tests_run++;
      if (seen !== want) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check_flags();
      check("carry", carry_o, exp_c);
      check("nibble_carry", dc_o, exp_dc);
      check("zero", zero_o, exp_z);
      check("gie", gie_o, exp_gie);
   endtask

   // reset held five cycles; inputs move on falling edges only
   task automatic apply_reset();
      rst_n_i = 1'b0;
      op_valid_i = 1'b0;
      wake_i = 1'b0;
      repeat (5) @(negedge clk_i);
      rst_n_i = 1'b1;
      {exp_w, exp_c, exp_dc, exp_z, exp_gie} = '0;
      check("work", work_o, 8'h00);
      check("sleep", sleep_o, 1'b0);
      check("busy", busy_o, 1'b0);
      check("expiry", expiry_o, 1'b1);
      check("entry", entry_o, 1'b1);
      check_flags();
   endtask

   // valid left high so ops run back to back; the caller drops it
   task automatic exec_alu(input mrs_pkg::mrs_op_type op, input logic [7:0] f,
                           input logic [7:0] lit, input logic d);
      logic [8:0] sum;
      logic [4:0] low;
      logic [7:0] res;
      logic [7:0] a;
      logic       cin;
      logic       to_file;
      to_file = d;
      res = 8'h00;
      case (op)
         mrs_pkg::ROTATE_LEFT_OP: begin
            res = {f[6:0], exp_c};
            exp_c = f[7];
         end
         mrs_pkg::ROTATE_RIGHT_OP: begin
            res = {exp_c, f[7:1]};
            exp_c = f[0];
         end
         mrs_pkg::NIBBLE_EXCHANGE_OP: res = {f[3:0], f[7:4]};
         mrs_pkg::XOR_REG_OP: res = exp_w ^ f;
         mrs_pkg::XOR_LITERAL_OP: res = exp_w ^ lit;
         default: begin
            // subtract family: operand plus inverted work plus carry-in
            a = (op == mrs_pkg::LITERAL_MINUS_WORK_OP) ? lit : f;
            cin = (op == mrs_pkg::SUB_BORROW_OP) ? exp_c : 1'b1;
            sum = {1'b0, a} + {1'b0, ~exp_w} + {8'h00, cin};
            low = {1'b0, a[3:0]} + {1'b0, ~exp_w[3:0]} + {4'h0, cin};
            res = sum[7:0];
            exp_c = sum[8];
            exp_dc = low[4];
         end
      endcase
      if (op == mrs_pkg::XOR_LITERAL_OP || op == mrs_pkg::LITERAL_MINUS_WORK_OP) begin
         to_file = 1'b0;
      end
      if (!(op inside {mrs_pkg::ROTATE_LEFT_OP, mrs_pkg::ROTATE_RIGHT_OP,
                       mrs_pkg::NIBBLE_EXCHANGE_OP})) begin
         exp_z = (res == 8'h00);
      end
      if (!to_file) begin
         exp_w = res;
      end
      op_valid_i = 1'b1;
      op_i = op;
      file_reg_i = f;
      literal_i = lit;
      dest_sel_i = d;
      @(posedge clk_i);
      @(negedge clk_i);
      check("work", work_o, exp_w);
      check("wdata", wdata_o, res);
      check("file_wr", file_wr_o, to_file);
      check("pc_load", pc_load_o, 1'b0);
      check_flags();
   endtask

   task automatic idle();
      op_valid_i = 1'b0;
      @(negedge clk_i);
   endtask

   // ******************************
   // scenarios
   // ******************************
   task automatic rotate_cases();
      exec_alu(mrs_pkg::XOR_LITERAL_OP, 8'h00, 8'h81, 1'b1);
      exec_alu(mrs_pkg::ROTATE_LEFT_OP, 8'h81, 8'h00, 1'b0);
      exec_alu(mrs_pkg::ROTATE_LEFT_OP, 8'h40, 8'h00, 1'b1);
      exec_alu(mrs_pkg::ROTATE_RIGHT_OP, 8'h01, 8'h00, 1'b1);
      exec_alu(mrs_pkg::ROTATE_RIGHT_OP, 8'h80, 8'h00, 1'b0);
      idle();
   endtask

   // equal operands, borrows in each nibble and both carry-in values
   task automatic subtract_cases();
      exec_alu(mrs_pkg::REG_MINUS_WORK_OP, exp_w, 8'h00, 1'b1);
      exec_alu(mrs_pkg::REG_MINUS_WORK_OP, 8'h10, 8'h00, 1'b0);
      exec_alu(mrs_pkg::SUB_BORROW_OP, 8'h50, 8'h00, 1'b1);
      exec_alu(mrs_pkg::SUB_BORROW_OP, 8'h60, 8'h00, 1'b0);
      exec_alu(mrs_pkg::SUB_BORROW_OP, 8'h3f, 8'h00, 1'b0);
      exec_alu(mrs_pkg::LITERAL_MINUS_WORK_OP, 8'h00, 8'h08, 1'b1);
      exec_alu(mrs_pkg::LITERAL_MINUS_WORK_OP, 8'h00, exp_w, 1'b0);
      idle();
   endtask

   task automatic swap_xor_cases();
      exec_alu(mrs_pkg::NIBBLE_EXCHANGE_OP, 8'h3c, 8'h00, 1'b1);
      exec_alu(mrs_pkg::NIBBLE_EXCHANGE_OP, 8'ha7, 8'h00, 1'b0);
      exec_alu(mrs_pkg::XOR_REG_OP, 8'h0f, 8'h00, 1'b1);
      exec_alu(mrs_pkg::XOR_REG_OP, exp_w, 8'h00, 1'b0);
      exec_alu(mrs_pkg::XOR_LITERAL_OP, 8'h00, 8'ha5, 1'b0);
      idle();
   endtask

   // an op offered in the second cycle of a return must be dropped
   task automatic ret_check(input mrs_pkg::mrs_op_type op, input logic [10:0] stk,
                            input logic [7:0] lit);
      if (op == mrs_pkg::RETURN_WITH_LITERAL_OP) exp_w = lit;
      if (op == mrs_pkg::IRQ_RETURN_OP) exp_gie = mrs_pkg::GIE_ON;
      op_valid_i = 1'b1;
      op_i = op;
      stack_top_i = stk;
      literal_i = lit;
      @(posedge clk_i);
      @(negedge clk_i);
      check("pc", pc_o, stk);
      check("pc_load", pc_load_o, 1'b1);
      check("pop", pop_o, 1'b1);
      check("busy", busy_o, 1'b1);
      check("work", work_o, exp_w);
      check_flags();
      op_i = mrs_pkg::XOR_LITERAL_OP;
      literal_i = 8'hff;
      @(posedge clk_i);
      @(negedge clk_i);
      check("busy", busy_o, 1'b0);
      check("pc_load", pc_load_o, 1'b0);
      check("work", work_o, exp_w);
   endtask

   task automatic return_cases();
      ret_check(mrs_pkg::SUB_RETURN_OP, 11'h7ff, 8'h00);
      ret_check(mrs_pkg::RETURN_WITH_LITERAL_OP, 11'h2a5, 8'hc3);
      ret_check(mrs_pkg::IRQ_RETURN_OP, 11'h001, 8'h00);
      idle();
   endtask

   task automatic sleep_case();
      int n;
      op_valid_i = 1'b1;
      op_i = mrs_pkg::SLEEP_OP;
      @(posedge clk_i);
      @(negedge clk_i);
      check("sleep", sleep_o, 1'b1);
      check("wdt_clr", wdt_clr_o, 1'b1);
      check("pre_clr", pre_clr_o, 1'b1);
      check("expiry", expiry_o, 1'b1);
      check("entry", entry_o, 1'b0);
      op_i = mrs_pkg::XOR_LITERAL_OP;
      literal_i = 8'hff;
      repeat (3) @(negedge clk_i);
      check("wdt_clr", wdt_clr_o, 1'b0);
      check("sleep", sleep_o, 1'b1);
      check("work", work_o, exp_w);
      op_valid_i = 1'b0;
      wake_i = 1'b1;
      n = 0;
      while (sleep_o === 1'b1 && n < 4) begin
         @(negedge clk_i);
         n++;
      end
      wake_i = 1'b0;
      check("wake", sleep_o, 1'b0);
      if (sleep_o !== 1'b0) begin
         return;
      end
      check("wake_cycles", 16'(n), 16'h0001);
      @(negedge clk_i);
      check("entry", entry_o, 1'b0);
      exec_alu(mrs_pkg::XOR_LITERAL_OP, 8'h00, 8'h3c, 1'b0);
      idle();
   endtask

   // ******************************
   // main sequence
   // ******************************
   initial begin
      fails = 0;
      tests_run = 0;
      op_i = mrs_pkg::OP_NONE;
      file_reg_i = 8'h00;
      literal_i = 8'h00;
      dest_sel_i = 1'b0;
      stack_top_i = 11'h000;
      apply_reset();
      rotate_cases();
      subtract_cases();
      swap_xor_cases();
      return_cases();
      sleep_case();
      apply_reset();
      close_out();
   end
endmodule
